// file: logic/crr_pkg.sv
// Package with constants and types for the calibration record registers
// What this block does
// - Resistor value is two independent 16-bit halves
// - Low half at 180, high half at 182
// - Hardware never alters nor uses stored bits
// - Contents go out as o_nv_image and come back by i_nv_load restore; reset clears them
// - Terminal module changes leave record untouched
package crr_pkg;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [8:0]  ADDR_RES_LO    = 9'h180;
  localparam logic [8:0]  ADDR_RES_HI    = 9'h182;
  localparam logic [8:0]  ADDR_VOLT_DONE = 9'h184;
  localparam logic [8:0]  ADDR_CURR_DONE = 9'h186;
  localparam logic [8:0]  ADDR_ISO       = 9'h188;
  localparam logic [8:0]  ADDR_CFG       = 9'h18a;
  localparam int          NUM_REGS       = 6;
  localparam int          CFG_LSB        = 3;
  localparam int          CFG_MSB        = 5;
  localparam logic [15:0] CFG_MASK       = 16'h0038;
  localparam logic [15:0] RESET_VALUE    = 16'h0000;

  // ----------------------------------------------------------------
  // Bus carrier
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        rd;
    logic        wr;
    logic [8:0]  addr;
    logic [15:0] wdata;
  } crr_req_type;

endpackage

// file: logic/crr_word_cell.sv
// One 16-bit storage word with a write mask and a load port
`timescale 1ns/1ps
module crr_word_cell
(
  input  wire logic        i_ref_clk,
  input  wire logic        i_nrst,
  input  wire logic        i_wr,
  input  wire logic [15:0] i_mask,
  input  wire logic [15:0] i_wdata,
  input  wire logic        i_load,
  input  wire logic [15:0] i_load_data,
  output logic      [15:0] o_q
);

  logic [15:0] q_ff;
  logic [15:0] nxt_q;

  // ----------------------------------------------------------------
  // Next value
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_q = q_ff;
    if (i_load)
    begin
      nxt_q = i_load_data & i_mask;
    end
    else if (i_wr)
    begin
      nxt_q = i_wdata & i_mask;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      q_ff <= crr_pkg::RESET_VALUE;
    end
    else
    begin
      q_ff <= nxt_q;
    end
  end

  assign o_q = q_ff;

endmodule // crr_word_cell

// file: logic/crr_cal_record_regs.sv
// Top of the calibration record register bank
`timescale 1ns/1ps
module crr_cal_record_regs
(
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_nrst,
  input  wire crr_pkg::crr_req_type i_req,
  input  wire logic                 i_nv_load,
  input  wire logic [95:0]          i_nv_data,
  output logic      [15:0]          o_rdata,
  output logic                      o_ack,
  output logic      [95:0]          o_nv_image,
  output logic                      o_nv_dirty
);

  // ----------------------------------------------------------------
  // Address decode
  // ----------------------------------------------------------------
  function automatic logic [8:0] reg_addr(input int idx);
    unique case (idx)
      0: reg_addr = crr_pkg::ADDR_RES_LO;
      1: reg_addr = crr_pkg::ADDR_RES_HI;
      2: reg_addr = crr_pkg::ADDR_VOLT_DONE;
      3: reg_addr = crr_pkg::ADDR_CURR_DONE;
      4: reg_addr = crr_pkg::ADDR_ISO;
      default: reg_addr = crr_pkg::ADDR_CFG;
    endcase
  endfunction

  function automatic logic [15:0] reg_mask(input int idx);
    reg_mask = (idx == 5) ? crr_pkg::CFG_MASK : 16'hffff;
  endfunction

  // ----------------------------------------------------------------
  // Read select
  // ----------------------------------------------------------------
  // Unmapped offsets fall through to zero so a stray read never
  // shows stale storage.
  function automatic logic [15:0] read_sel
  (
    input logic [crr_pkg::NUM_REGS-1:0] sel,
    input logic [95:0]                  img
  );
    read_sel = 16'h0000;
    for (int i = 0; i < crr_pkg::NUM_REGS; i++)
    begin
      if (sel[i])
      begin
        read_sel = img[i*16 +: 16];
      end
    end
  endfunction

  logic [15:0]                  word_q [crr_pkg::NUM_REGS];
  logic [crr_pkg::NUM_REGS-1:0] hit;
  logic [crr_pkg::NUM_REGS-1:0] wr_en;
  logic [95:0]                  image;

  // ----------------------------------------------------------------
  // Storage words
  // ----------------------------------------------------------------
  // Words are plain storage: only host writes or the non-volatile
  // image restore change them, no other logic reads them.
  genvar g;
  generate
    for (g = 0; g < crr_pkg::NUM_REGS; g++)
    begin : g_word
      assign hit[g]   = (i_req.addr == reg_addr(g));
      assign wr_en[g] = i_req.wr & hit[g];
      crr_word_cell u_cell
      (
        .i_ref_clk   (i_ref_clk),
        .i_nrst      (i_nrst),
        .i_wr        (wr_en[g]),
        .i_mask      (reg_mask(g)),
        .i_wdata     (i_req.wdata),
        .i_load      (i_nv_load),
        .i_load_data (i_nv_data[g*16 +: 16]),
        .o_q         (word_q[g])
      );
      assign image[g*16 +: 16] = word_q[g];
    end
  endgenerate

  assign o_nv_image = image;

  // ----------------------------------------------------------------
  // Read data
  // ----------------------------------------------------------------
  logic [15:0] rdata_ff;
  logic [15:0] nxt_rdata;

  // A read in the same cycle as a write returns the old word.
  always_comb
  begin
    nxt_rdata = rdata_ff;
    if (i_req.rd)
    begin
      nxt_rdata = read_sel(hit, image);
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      rdata_ff <= 16'h0000;
    end
    else
    begin
      rdata_ff <= nxt_rdata;
    end
  end

  // ----------------------------------------------------------------
  // Acknowledge
  // ----------------------------------------------------------------
  logic ack_ff;
  logic nxt_ack;

  // Every strobe is answered, mapped or not, so a host never hangs.
  always_comb
  begin
    nxt_ack = i_req.rd | i_req.wr;
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      ack_ff <= 1'b0;
    end
    else
    begin
      ack_ff <= nxt_ack;
    end
  end

  // ----------------------------------------------------------------
  // Dirty flag
  // ----------------------------------------------------------------
  logic dirty_ff;
  logic nxt_dirty;

  // A write wins over a restore in this flag; the word cell keeps the restored value.
  always_comb
  begin
    nxt_dirty = dirty_ff;
    if (i_nv_load)
    begin
      nxt_dirty = 1'b0;
    end
    if (|wr_en)
    begin
      nxt_dirty = 1'b1;
    end
  end

  always_ff @(posedge i_ref_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      dirty_ff <= 1'b0;
    end
    else
    begin
      dirty_ff <= nxt_dirty;
    end
  end

  // Terminal module state has no port here, so it cannot disturb
  // the stored record.
  assign o_rdata    = rdata_ff;
  assign o_ack      = ack_ff;
  assign o_nv_dirty = dirty_ff;

endmodule // crr_cal_record_regs

// file: testbench/crr_checker.sv
// Port assertions for the calibration record bank
`timescale 1ns/1ps
module crr_checker
(
  input wire logic                 i_ref_clk,
  input wire logic                 i_nrst,
  input wire crr_pkg::crr_req_type i_req,
  input wire logic                 i_nv_load,
  input wire logic [95:0]          i_nv_data,
  input wire logic [15:0]          o_rdata,
  input wire logic                 o_ack,
  input wire logic [95:0]          o_nv_image,
  input wire logic                 o_nv_dirty
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (!i_nrst);
  sequence lo_wr_s;
    i_req.wr && i_req.addr == 9'h180 && !i_nv_load;
  endsequence
  sequence hi_wr_s;
    i_req.wr && i_req.addr == 9'h182 && !i_nv_load;
  endsequence
  ack_pulse_a: assert property
    (o_ack == $past(i_req.rd | i_req.wr)) else $error("late ack");
  low_word_a: assert property
    (lo_wr_s |=> o_nv_image[15:0] == $past(i_req.wdata)) else $error("lo");
  high_word_a: assert property
    (hi_wr_s |=> o_nv_image[31:16] == $past(i_req.wdata)) else $error("hi");
  low_read_a: assert property
    (i_req.rd && i_req.addr == 9'h180 |=> o_rdata == $past(o_nv_image[15:0]))
    else $error("bad read");
  cfg_mask_a: assert property
    ((o_nv_image[95:80] & 16'hffc7) == 16'h0000) else $error("cfg bits");
  // Without a write or load nothing may move the stored words
  hold_store_a: assert property
    (!i_req.wr && !i_nv_load |=> $stable(o_nv_image)) else $error("moved");
  nv_restore_a: assert property
    (i_nv_load |=> o_nv_image[79:0] == $past(i_nv_data[79:0]))
    else $error("restore");
  dirty_set_a: assert property
    (lo_wr_s or hi_wr_s |=> o_nv_dirty) else $error("dirty not set");
  dirty_clear_a: assert property
    (i_nv_load && !i_req.wr |=> !o_nv_dirty) else $error("dirty kept");
endmodule // crr_checker
bind crr_cal_record_regs crr_checker i_chk (.i_ref_clk(i_ref_clk),
  .i_nrst(i_nrst), .i_req(i_req), .i_nv_load(i_nv_load),
  .i_nv_data(i_nv_data), .o_rdata(o_rdata), .o_ack(o_ack),
  .o_nv_image(o_nv_image), .o_nv_dirty(o_nv_dirty));

// file: testbench/crr_host_model.sv
// Host model issuing single register reads and writes
`timescale 1ns/1ps
module crr_host_model
(
  input  wire logic            i_ref_clk,
  input  wire logic [15:0]     i_rdata,
  input  wire logic            i_ack,
  output crr_pkg::crr_req_type o_req
);
  initial o_req = '0;
  // Idle bus shows inverted junk so stale values never pass
  task automatic acc(input logic w, input logic [8:0] a,
    input logic [15:0] d, output logic [15:0] q);
    @(negedge i_ref_clk);
    o_req = '{rd: ~w, wr: w, addr: a, wdata: d};
    @(negedge i_ref_clk);
    o_req = '{rd: 1'b0, wr: 1'b0, addr: ~a, wdata: ~d};
    q = i_ack ? i_rdata : 16'hdead;
  endtask
endmodule // crr_host_model

// file: testbench/tb_cal_record_registers.sv
// Self-checking bench for the calibration record bank
`timescale 1ns/1ps
module tb_cal_record_registers;
  logic                 i_ref_clk, i_nrst, i_nv_load, o_ack, o_nv_dirty;
  logic [95:0]          i_nv_data, o_nv_image, e;
  logic [15:0]          o_rdata, q;
  crr_pkg::crr_req_type req;
  int                   error_cnt = 0, checks = 0;
  crr_cal_record_regs i_dut (.i_ref_clk(i_ref_clk), .i_nrst(i_nrst),
    .i_req(req), .i_nv_load(i_nv_load), .i_nv_data(i_nv_data),
    .o_rdata(o_rdata), .o_ack(o_ack), .o_nv_image(o_nv_image),
    .o_nv_dirty(o_nv_dirty));
  crr_host_model i_host (.i_ref_clk(i_ref_clk), .i_rdata(o_rdata),
    .i_ack(o_ack), .o_req(req));
  task automatic chk(input logic [95:0] s, input logic [95:0] x);
    checks++;
    if (s !== x)
    begin
      error_cnt++;
      $display("mismatch %0t %h %h", $time, s, x);
    end
  endtask
  task automatic wrap_up();
    $display("errors %0d checks %0d", error_cnt, checks);
    if (error_cnt == 0 && checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  task automatic t_map();
    for (int n = 0; n < 6; n++)
    begin
      e[16*n+:16] = (n == 5) ? 16'hffff : 16'h8421 << n;
      i_host.acc(1'b1, 9'h180 + 9'(2*n), e[16*n+:16], q);
    end
    e[95:80] = 16'h0038;
    chk(o_nv_image, e);
    chk(96'(o_nv_dirty), 96'h1);
    for (int n = 0; n < 6; n++)
    begin
      i_host.acc(1'b0, 9'h180 + 9'(2*n), 16'h0000, q);
      chk(96'(q), 96'(e[16*n+:16]));
    end
  endtask
  task automatic t_refuse();
    i_host.acc(1'b1, 9'h18c, 16'hffff, q);
    i_host.acc(1'b0, 9'h18c, 16'h0000, q);
    chk(96'(q), 96'h0);
    chk(o_nv_image, e);
  endtask
  task automatic t_load();
    @(negedge i_ref_clk);
    i_nv_data = 96'h1234_5678_9abc_def0_0f0f_f0f0;
    i_nv_load = 1'b1;
    @(negedge i_ref_clk);
    i_nv_load = 1'b0;
    chk(o_nv_image, {16'h0030, i_nv_data[79:0]});
    chk(96'(o_nv_dirty), 96'h0);
    i_host.acc(1'b1, 9'h18c, 16'h5555, q);
    chk(96'(o_nv_dirty), 96'h0);
  endtask
  task automatic t_flags();
    i_host.acc(1'b1, 9'h184, 16'h8001, q);
    i_host.acc(1'b0, 9'h184, 16'h0000, q);
    chk(96'(q), 96'h8001);
    i_host.acc(1'b1, 9'h186, 16'h4002, q);
    i_host.acc(1'b0, 9'h186, 16'h0000, q);
    chk(96'(q), 96'h4002);
    i_host.acc(1'b1, 9'h188, 16'h2004, q);
    i_host.acc(1'b0, 9'h188, 16'h0000, q);
    chk(96'(q), 96'h2004);
    i_host.acc(1'b1, 9'h18a, 16'hffc7, q);
    i_host.acc(1'b0, 9'h18a, 16'h0000, q);
    chk(96'(q), 96'h0);
    chk(96'(q[5:3] != 3'b111), 96'h1);
    chk(96'(o_nv_dirty), 96'h1);
  endtask
  initial
  begin
    i_ref_clk = 1'b0;
    forever #2.5 i_ref_clk = ~i_ref_clk;
  end
  initial
  begin
    #100us;
    error_cnt++;
    wrap_up();
  end
  initial
  begin
    {i_nrst, i_nv_load, i_nv_data, e} = '0;
    repeat (5) @(negedge i_ref_clk);
    i_nrst = 1'b1;
    t_map();
    t_refuse();
    t_load();
    t_flags();
    wrap_up();
  end
endmodule // tb_cal_record_registers
